// file: hdl/rfr_pkg.sv
// Package: constants for the rail fault response command block
package rfr_pkg;

	// ------------------------------------------------------------
	// Command codes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_LISTEN_VEC  = 8'hF0;
	localparam logic [7:0] CMD_CAPTURE_OP  = 8'hF3;
	localparam logic [7:0] CMD_OVER_LIMIT  = 8'hF5;
	localparam logic [7:0] CMD_UNDER_LIMIT = 8'hF6;
	localparam logic [7:0] CMD_OVER_RESP   = 8'hF8;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [31:0] RST_LISTEN_VEC = 32'h0000_0000;
	localparam logic [7:0]  RST_CAPTURE_OP = 8'h00;
	localparam logic [15:0] RST_OVER_LIM   = 16'h0000;
	localparam logic [15:0] RST_UNDER_LIM  = 16'h0000;
	localparam logic [7:0]  RST_OVER_RESP  = 8'h00;

	// ------------------------------------------------------------
	// Field layout
	// ------------------------------------------------------------
	localparam int RESP_HI  = 7;
	localparam int RESP_LO  = 6;
	localparam int RETRY_HI = 5;
	localparam int RETRY_LO = 3;
	localparam int TIME_HI  = 2;
	localparam int TIME_LO  = 0;
	localparam int MANT_HI  = 10;
	localparam int EXP_LO   = 11;

	localparam logic [1:0] RESP_IGNORE = 2'h0;
	localparam logic [1:0] RESP_RETRY  = 2'h2;
	localparam logic [1:0] RESP_RESUME = 2'h3;
	localparam logic [2:0] RETRY_NONE  = 3'h0;
	localparam logic [2:0] RETRY_ENDLESS = 3'h7;

	localparam logic [7:0] CAP_COPY  = 8'h01;
	localparam logic [7:0] CAP_STORE = 8'h02;
	localparam logic [7:0] CAP_ERASE = 8'h03;

	// ------------------------------------------------------------
	// Percent figures and timing
	// ------------------------------------------------------------
	localparam int OVER_WARN_PCT  = 90;
	localparam int UNDER_WARN_PCT = 110;
	localparam int RESUME_PCT     = 95;
	localparam int CLK_HZ         = 40_000_000;
	localparam int RETRY_STEP_MS  = 35;
	localparam int RETRY_STEP_CYC = CLK_HZ / 1000 * RETRY_STEP_MS;
	localparam int DIV_W          = 21;

	typedef enum logic [3:0] {
		RFR_RUN    = 4'b0001,
		RFR_WAIT   = 4'b0010,
		RFR_HOLD   = 4'b0100,
		RFR_RESUME = 4'b1000
	} rfr_state_e;

endpackage

// file: hdl/rfr_core.sv
// Command registers and fault response logic of a point-of-load rail
// Function
// R1 - Four-byte listen vector, one bit per peer rail, selects which peers we react to.
// R2 - Bit 0 of byte 0 is rail 0, bit 7 of byte 3 is rail 31.
// R3 - Host must not set our own rail bit in the listen vector.
// R4 - Shared rail reports shutdown only once all sharing devices are off.
// R5 - Spreading enabled: shut down at once when a listened peer fails.
// R6 - After spread shutdown, restart only when all group faults clear.
// R7 - Spreading disabled: request sequenced shutdown on a group fault.
// R8 - Sequenced devices restart only after all group faults clear.
// R9 - Spreading and sequencing disabled: ignore peer faults, stay enabled.
// R10 - Capture op byte: 01 copy to RAM, 02 store, 03 erase.
// R11 - Host should issue capture operations only with output disabled.
// R12 - Writing over limit sets over warning to 90 percent of it.
// R13 - Writing under limit sets under warning to 110 percent of it.
// R14 - Both limits are 16-bit linear words, word read and write.
// R15 - Response bits 7:6: 00 ignore, 10 off and retry, 11 off and resume.
// R16 - Any response code: alert low and fault status bit set.
// R17 - Resume mode re-enables once voltage is below 95 percent of limit.
// R18 - Retry field 5:3 sets number of restart attempts.
// R19 - Retry count 000: no restart, off until fault cleared.
// R20 - Retry count 111: retry endlessly until commanded off or other fault. Here only on_cmd_in low ends the retries.
// R21 - Retry spacing is (time field plus one) times 35 ms.
// R22 - Code 01 behaves as ignore but still alerts and sets status.
`timescale 1ns/1ps
module rfr_core
	import rfr_pkg::*;
#(
	parameter int STEP_CYC = RETRY_STEP_CYC
) (
	// Clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        arst_n_in,
	// Command port from the transaction layer
	input  wire logic        cmd_wr_in,
	input  wire logic        cmd_rd_in,
	input  wire logic [7:0]  cmd_code_in,
	input  wire logic [31:0] cmd_wdata_in,
	output logic      [31:0] cmd_rdata_out,
	output logic             cmd_ack_out,
	output logic             cmd_err_out,
	// Configuration and control levels
	input  wire logic        spread_en_in,
	input  wire logic        seq_en_in,
	input  wire logic        on_cmd_in,
	input  wire logic        clear_faults_in,
	// Group bus and current share
	input  wire logic [31:0] peer_fault_in,
	input  wire logic        share_peers_off_in,
	// Driver supply monitor
	input  wire logic [15:0] drv_volt_in,
	// Outputs
	output logic             output_en_out,
	output logic             seq_shutdown_out,
	output logic             rail_off_out,
	output logic             alert_n_out,
	output logic             ov_fault_stat_out,
	output logic             ov_warn_stat_out,
	output logic [15:0]      over_warn_out,
	output logic [15:0]      under_warn_out,
	output logic             cap_copy_out,
	output logic             cap_store_out,
	output logic             cap_erase_out
);
	import rfr_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [31:0] listen;
		logic [7:0]  cap_op;
		logic [15:0] over_lim;
		logic [15:0] under_lim;
		logic [15:0] over_warn;
		logic [15:0] under_warn;
		logic [7:0]  over_resp;
		rfr_state_e  st;
		logic [DIV_W-1:0] div_cnt;
		logic [2:0]  step_cnt;
		logic [2:0]  tries;
		logic        alert;
		logic        ov_stat;
		logic        warn_stat;
		logic        spread_off;
		logic        seq_off;
		logic [31:0] rdata;
		logic        ack;
		logic        err;
		logic        cp;
		logic        sto;
		logic        era;
	} rfr_state_s;

	rfr_state_s cur;
	rfr_state_s next_cur;

	// Linear word scaled by pct/100; the exponent is bumped when the
	// mantissa would leave its 11-bit signed range, losing one LSB.
	function automatic logic [15:0] lin_scale(input logic [15:0] w, input int pct);
		logic signed [31:0] p;
		logic [4:0]         e;
		p = 32'(($signed({{21{w[MANT_HI]}}, w[MANT_HI:0]}) * pct) / 100);
		e = w[15:EXP_LO];
		if (p > 32'sd1023 || p < -32'sd1024) begin
			p = p >>> 1;
			e = 5'(e + 5'h1);
		end
		return {e, p[MANT_HI:0]};
	endfunction

	// ------------------------------------------------------------
	// Combinational terms
	// ------------------------------------------------------------
	logic signed [31:0] volt_m;
	logic signed [31:0] lim_m;
	logic signed [31:0] warn_m;
	logic               ov_now;
	logic               below_resume;
	logic               grp_fault;
	logic               step_tick;
	logic [1:0]         resp;
	logic [2:0]         retry_max;

	// Mantissas are compared directly: the monitor and the limits are
	// expected to share one exponent.
	assign volt_m       = 32'($signed(drv_volt_in[MANT_HI:0]));
	assign lim_m        = 32'($signed(cur.over_lim[MANT_HI:0]));
	assign warn_m       = 32'($signed(cur.over_warn[MANT_HI:0]));
	assign ov_now       = volt_m > lim_m;
	assign below_resume = (volt_m * 100) < (lim_m * RESUME_PCT); // R17
	assign grp_fault    = |(peer_fault_in & cur.listen); // R1 R2
	assign step_tick    = cur.div_cnt == DIV_W'(STEP_CYC - 1);
	assign resp         = cur.over_resp[RESP_HI:RESP_LO];
	assign retry_max    = cur.over_resp[RETRY_HI:RETRY_LO];

	always_comb begin
		next_cur     = cur;
		next_cur.ack = 1'b0;
		next_cur.err = 1'b0;
		next_cur.cp  = 1'b0;
		next_cur.sto = 1'b0;
		next_cur.era = 1'b0;

		// --------------------------------------------------------
		// Register writes and reads
		// --------------------------------------------------------
		if (cmd_wr_in) begin
			next_cur.ack = 1'b1;
			case (cmd_code_in)
				CMD_LISTEN_VEC: next_cur.listen = cmd_wdata_in; // R1
				CMD_CAPTURE_OP: begin
					next_cur.cap_op = cmd_wdata_in[7:0];
					next_cur.cp  = cmd_wdata_in[7:0] == CAP_COPY; // R10
					next_cur.sto = cmd_wdata_in[7:0] == CAP_STORE; // R10
					next_cur.era = cmd_wdata_in[7:0] == CAP_ERASE; // R10
				end
				CMD_OVER_LIMIT: begin
					next_cur.over_lim  = cmd_wdata_in[15:0]; // R14
					next_cur.over_warn = lin_scale(cmd_wdata_in[15:0], OVER_WARN_PCT); // R12
				end
				CMD_UNDER_LIMIT: begin
					next_cur.under_lim  = cmd_wdata_in[15:0]; // R14
					next_cur.under_warn = lin_scale(cmd_wdata_in[15:0], UNDER_WARN_PCT); // R13
				end
				CMD_OVER_RESP: next_cur.over_resp = cmd_wdata_in[7:0];
				default: next_cur.err = 1'b1;
			endcase
		end else if (cmd_rd_in) begin
			next_cur.ack = 1'b1;
			case (cmd_code_in)
				CMD_LISTEN_VEC:  next_cur.rdata = cur.listen;
				CMD_CAPTURE_OP:  next_cur.rdata = {24'h000000, cur.cap_op};
				CMD_OVER_LIMIT:  next_cur.rdata = {16'h0000, cur.over_lim}; // R14
				CMD_UNDER_LIMIT: next_cur.rdata = {16'h0000, cur.under_lim}; // R14
				CMD_OVER_RESP:   next_cur.rdata = {24'h000000, cur.over_resp};
				default: begin
					next_cur.rdata = 32'h0000_0000;
					next_cur.err   = 1'b1;
				end
			endcase
		end

		// --------------------------------------------------------
		// Status flags: a set in the clearing cycle wins
		// --------------------------------------------------------
		if (clear_faults_in) begin
			next_cur.alert     = 1'b0;
			next_cur.ov_stat   = 1'b0;
			next_cur.warn_stat = 1'b0;
		end
		if (ov_now) begin
			next_cur.alert   = 1'b1; // R16 R22
			next_cur.ov_stat = 1'b1; // R16 R22
		end
		if (volt_m > warn_m)
			next_cur.warn_stat = 1'b1;

		// --------------------------------------------------------
		// Group fault handling
		// --------------------------------------------------------
		if (spread_en_in) begin
			next_cur.seq_off = 1'b0;
			if (grp_fault)
				next_cur.spread_off = 1'b1; // R5
			else
				next_cur.spread_off = 1'b0; // R6
		end else if (seq_en_in) begin
			next_cur.spread_off = 1'b0;
			next_cur.seq_off    = grp_fault; // R7 R8
		end else begin
			next_cur.spread_off = 1'b0; // R9
			next_cur.seq_off    = 1'b0; // R9
		end

		// --------------------------------------------------------
		// Overvoltage response
		// --------------------------------------------------------
		next_cur.div_cnt = step_tick ? '0 : DIV_W'(cur.div_cnt + 1'b1);
		case (cur.st)
			RFR_RUN: begin
				if (!on_cmd_in)
					next_cur.tries = 3'h0;
				else if (ov_now && resp == RESP_RETRY) begin // R15
					next_cur.div_cnt  = '0;
					next_cur.step_cnt = 3'h0;
					if (retry_max == RETRY_NONE) // R19
						next_cur.st = RFR_HOLD;
					else if (retry_max != RETRY_ENDLESS && cur.tries >= retry_max) // R18
						next_cur.st = RFR_HOLD;
					else
						next_cur.st = RFR_WAIT; // R20
				end else if (ov_now && resp == RESP_RESUME)
					next_cur.st = RFR_RESUME; // R15
			end
			RFR_WAIT: begin
				if (!on_cmd_in) begin
					next_cur.st    = RFR_RUN; // R20
					next_cur.tries = 3'h0;
				end else if (step_tick) begin
					next_cur.step_cnt = 3'(cur.step_cnt + 3'h1);
					if (cur.step_cnt == cur.over_resp[TIME_HI:TIME_LO]) begin // R21
						next_cur.st = RFR_RUN;
						if (retry_max != RETRY_ENDLESS)
							next_cur.tries = 3'(cur.tries + 3'h1); // R18
					end
				end
			end
			RFR_HOLD: begin
				if (clear_faults_in || !on_cmd_in) begin // R19
					next_cur.st    = RFR_RUN;
					next_cur.tries = 3'h0;
				end
			end
			RFR_RESUME: begin
				if (below_resume)
					next_cur.st = RFR_RUN; // R17
			end
			default: next_cur.st = RFR_RUN;
		endcase
		if (clear_faults_in && cur.st == RFR_RUN)
			next_cur.tries = 3'h0;
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cur            <= '0;
			cur.listen     <= RST_LISTEN_VEC;
			cur.cap_op     <= RST_CAPTURE_OP;
			cur.over_lim   <= RST_OVER_LIM;
			cur.under_lim  <= RST_UNDER_LIM;
			cur.over_warn  <= RST_OVER_LIM;
			cur.under_warn <= RST_UNDER_LIM;
			cur.over_resp  <= RST_OVER_RESP;
			cur.st         <= RFR_RUN;
		end else begin
			cur <= next_cur;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign cmd_rdata_out     = cur.rdata;
	assign cmd_ack_out       = cur.ack;
	assign cmd_err_out       = cur.err;
	assign output_en_out     = on_cmd_in && cur.st == RFR_RUN && !cur.spread_off && !cur.seq_off;
	assign seq_shutdown_out  = cur.seq_off; // R7
	assign rail_off_out      = !output_en_out && share_peers_off_in; // R4
	assign alert_n_out       = !cur.alert; // R16
	assign ov_fault_stat_out = cur.ov_stat;
	assign ov_warn_stat_out  = cur.warn_stat;
	assign over_warn_out     = cur.over_warn;
	assign under_warn_out    = cur.under_warn;
	assign cap_copy_out      = cur.cp;
	assign cap_store_out     = cur.sto;
	assign cap_erase_out     = cur.era;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!arst_n_in);

	sequence s_ov_retry;
		on_cmd_in && cur.st == RFR_RUN && ov_now && resp == RESP_RETRY;
	endsequence
	sequence s_ov_resume;
		on_cmd_in && cur.st == RFR_RUN && ov_now && resp == RESP_RESUME;
	endsequence

	AST_LISTEN_WR: assert property (cmd_wr_in && cmd_code_in == CMD_LISTEN_VEC |=> // R1
		cur.listen == $past(cmd_wdata_in)) else $error("listen vector not stored");
	AST_LISTEN_MAP: assert property (spread_en_in && // R2
		(peer_fault_in & cur.listen) != 32'h0000_0000 |=> !output_en_out)
		else $error("listened peer fault did not stop output");
	AST_SHARE_OFF: assert property (rail_off_out |-> share_peers_off_in && !output_en_out) // R4
		else $error("rail reported off early");
	AST_SPREAD: assert property (spread_en_in && grp_fault |=> cur.spread_off) // R5
		else $error("spread shutdown missed");
	AST_SPREAD_REL: assert property (spread_en_in && !grp_fault |=> !cur.spread_off) // R6
		else $error("spread release wrong");
	AST_SEQ: assert property (!spread_en_in && seq_en_in && grp_fault |=> seq_shutdown_out) // R7
		else $error("sequenced shutdown missed");
	AST_SEQ_REL: assert property (seq_shutdown_out |-> $past(grp_fault)) // R8
		else $error("sequenced restart before clear");
	AST_IGNORE: assert property (!spread_en_in && !seq_en_in |=> // R9
		!cur.spread_off && !cur.seq_off) else $error("peer fault not ignored");
	AST_CAP: assert property (cmd_wr_in && cmd_code_in == CMD_CAPTURE_OP && // R10
		cmd_wdata_in[7:0] == CAP_ERASE |=> cap_erase_out && !cap_copy_out && !cap_store_out)
		else $error("erase pulse wrong");
	AST_WARN_OV: assert property (cmd_wr_in && cmd_code_in == CMD_OVER_LIMIT |=> // R12
		over_warn_out == lin_scale(cur.over_lim, OVER_WARN_PCT))
		else $error("over warning not derived");
	AST_WARN_UV: assert property (cmd_wr_in && cmd_code_in == CMD_UNDER_LIMIT |=> // R13
		under_warn_out == lin_scale(cur.under_lim, UNDER_WARN_PCT))
		else $error("under warning not derived");
	AST_ALERT: assert property (ov_now |=> !alert_n_out && ov_fault_stat_out) // R16
		else $error("alert not raised");
	AST_RETRY_OFF: assert property (s_ov_retry |=> !output_en_out) // R15
		else $error("retry did not disable");
	AST_RESUME: assert property (s_ov_resume |=> cur.st == RFR_RESUME ##0 !output_en_out) // R15
		else $error("resume did not disable");
	AST_RESUME_REL: assert property (cur.st == RFR_RESUME && below_resume |=> // R17
		cur.st == RFR_RUN) else $error("resume release wrong");
	AST_NO_RETRY: assert property ((s_ov_retry and retry_max == RETRY_NONE) |=> // R19
		cur.st == RFR_HOLD) else $error("zero retry restarted");
	AST_ENDLESS: assert property ((s_ov_retry and retry_max == RETRY_ENDLESS) |=> // R20
		cur.st == RFR_WAIT) else $error("endless retry stopped");
	AST_STEP: assert property (cur.st == RFR_WAIT && // R21
		cur.step_cnt > cur.over_resp[TIME_HI:TIME_LO] |-> 1'b0) else $error("retry wait overran");
	AST_IGN01: assert property (on_cmd_in && cur.st == RFR_RUN && ov_now && // R22
		resp == 2'h1 |=> cur.st == RFR_RUN) else $error("code 01 not ignored");
	AST_SET_WINS: assert property (clear_faults_in && ov_now |=> // R16
		ov_fault_stat_out && !alert_n_out) else $error("clear beat a new fault");
	AST_WARN_SET: assert property (volt_m > warn_m |=> ov_warn_stat_out) // R12
		else $error("warning status missed");
	AST_ACK: assert property (cmd_wr_in || cmd_rd_in |=> cmd_ack_out) // R14
		else $error("command not acknowledged");
	AST_HOLD_STAY: assert property (cur.st == RFR_HOLD && on_cmd_in && // R19
		!clear_faults_in |=> cur.st == RFR_HOLD) else $error("hold left without clear");
	AST_RETRY_LIM: assert property ((s_ov_retry and // R18
		(retry_max != RETRY_ENDLESS && cur.tries >= retry_max)) |=> cur.st == RFR_HOLD)
		else $error("retry count overrun");

endmodule // rfr_core

// file: verif/rfr_peer_model.sv
// Peer regulators on the shared fault bus and the current-share line
`timescale 1ns/1ps
module rfr_peer_model (
	// Clock
	input  wire logic        clk_sys_in,
	// Scenario control
	input  wire logic [31:0] fault_mask_in,
	input  wire logic        share_off_in,
	// Toward the device
	output logic      [31:0] peer_fault_out,
	output logic             share_peers_off_out
);
	initial begin
		peer_fault_out = 32'h0;
		share_peers_off_out = 1'b0;
	end

	// Peers settle just after an edge, never on it
	always @(posedge clk_sys_in) begin
		peer_fault_out      <= #2 fault_mask_in;
		share_peers_off_out <= #2 share_off_in;
	end
endmodule // rfr_peer_model

// file: verif/test_rail_fault_response_cmds.sv
// Self-checking testbench for the rail fault response command block
`timescale 1ns/1ps
module test_rail_fault_response_cmds;
	import rfr_pkg::*;
	localparam int STEP = 8;
	logic        clk_sys_in = 0, arst_n_in = 0, cmd_wr_in = 0, cmd_rd_in = 0;
	logic [7:0]  cmd_code_in = 8'h00;
	logic [31:0] cmd_wdata_in = 32'h0, cmd_rdata_out, peer_fault, fault_mask = 32'h0;
	logic        cmd_ack_out, cmd_err_out, share_off = 0, share_peers_off;
	logic        spread_en_in = 0, seq_en_in = 0, on_cmd_in = 0, clear_faults_in = 0;
	logic [15:0] drv_volt_in = 16'h0000, over_warn_out, under_warn_out;
	logic        output_en_out, seq_shutdown_out, rail_off_out, alert_n_out;
	logic        ov_fault_stat_out, ov_warn_stat_out, cap_copy_out, cap_store_out;
	logic        cap_erase_out;
	int          error_cnt = 0, n_compared = 0;

	always #12.5 clk_sys_in = ~clk_sys_in;

	rfr_core #(.STEP_CYC(STEP)) u_dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
		.cmd_wr_in(cmd_wr_in), .cmd_rd_in(cmd_rd_in), .cmd_code_in(cmd_code_in),
		.cmd_wdata_in(cmd_wdata_in), .cmd_rdata_out(cmd_rdata_out), .cmd_ack_out(cmd_ack_out),
		.cmd_err_out(cmd_err_out), .spread_en_in(spread_en_in), .seq_en_in(seq_en_in),
		.on_cmd_in(on_cmd_in), .clear_faults_in(clear_faults_in), .peer_fault_in(peer_fault),
		.share_peers_off_in(share_peers_off), .drv_volt_in(drv_volt_in),
		.output_en_out(output_en_out), .seq_shutdown_out(seq_shutdown_out),
		.rail_off_out(rail_off_out), .alert_n_out(alert_n_out),
		.ov_fault_stat_out(ov_fault_stat_out), .ov_warn_stat_out(ov_warn_stat_out),
		.over_warn_out(over_warn_out), .under_warn_out(under_warn_out),
		.cap_copy_out(cap_copy_out), .cap_store_out(cap_store_out),
		.cap_erase_out(cap_erase_out));

	rfr_peer_model u_peer (.clk_sys_in(clk_sys_in), .fault_mask_in(fault_mask),
		.share_off_in(share_off), .peer_fault_out(peer_fault),
		.share_peers_off_out(share_peers_off));

	// ------------------------------------------------------------
	// Checking and bus tasks
	// ------------------------------------------------------------
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
		#2;
	endtask

	// One strobe, answer sampled in the cycle after the taking edge
	task automatic acc(input logic wr, input logic [7:0] code, input logic [31:0] wd,
		input logic [31:0] exp_rd, input logic exp_err);
		cyc(1);
		cmd_wr_in = wr;
		cmd_rd_in = !wr;
		cmd_code_in = code;
		cmd_wdata_in = wd;
		cyc(1);
		cmd_wr_in = 0;
		cmd_rd_in = 0;
		chk({31'h0, cmd_ack_out}, 32'h1);
		chk({31'h0, cmd_err_out}, {31'h0, exp_err});
		if (!wr) begin
			chk(cmd_rdata_out, exp_rd);
		end
	endtask

	task automatic wait_en(input logic v, input int lim);
		int i;
		for (i = 0; i < lim && output_en_out !== v; i++) begin
			cyc(1);
		end
		chk({31'h0, output_en_out}, {31'h0, v});
		if (output_en_out !== v) begin
			summarize();
		end
	endtask

	function automatic logic [15:0] warn(input logic [15:0] lim, input int pct);
		warn = {lim[15:11], 11'(int'(lim[10:0]) * pct / 100)};
	endfunction

	// Clean start, arm response, then raise the supply above the limit
	task automatic ov_trip(input logic [7:0] resp);
		drv_volt_in = 16'h0000;
		on_cmd_in = 0;
		clear_faults_in = 1;
		acc(1, CMD_OVER_RESP, {24'h0, resp}, 0, 0);
		clear_faults_in = 0;
		on_cmd_in = 1;
		cyc(2);
		chk({30'h0, alert_n_out, ov_fault_stat_out}, 32'h2);
		chk({31'h0, ov_warn_stat_out}, 32'h0);
		drv_volt_in = 16'h00C8;
		cyc(2);
		chk({30'h0, alert_n_out, ov_fault_stat_out}, 32'h1);
		chk({31'h0, ov_warn_stat_out}, 32'h1);
		chk({31'h0, output_en_out}, {31'h0, resp[7:6] < 2'h2});
	endtask

	initial begin
		repeat (100000) @(posedge clk_sys_in);
		error_cnt++;
		summarize();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] v;
		logic [15:0] lim;
		int k;
		v = $urandom(32'hD867_0329);
		repeat (10) @(posedge clk_sys_in);
		#2 arst_n_in = 1;
		acc(0, CMD_LISTEN_VEC, 0, RST_LISTEN_VEC, 0);
		acc(0, CMD_CAPTURE_OP, 0, {24'h0, RST_CAPTURE_OP}, 0);
		acc(0, CMD_OVER_LIMIT, 0, {16'h0, RST_OVER_LIM}, 0);
		acc(0, CMD_UNDER_LIMIT, 0, {16'h0, RST_UNDER_LIM}, 0);
		acc(0, CMD_OVER_RESP, 0, {24'h0, RST_OVER_RESP}, 0);
		acc(1, 8'hF1, 32'hFF, 0, 1);
		acc(0, 8'hF1, 0, 0, 1);
		for (k = 0; k < 4; k++) begin
			v = $urandom();
			acc(1, CMD_LISTEN_VEC, v, 0, 0);
			acc(0, CMD_LISTEN_VEC, 0, v, 0);
			lim = {5'($urandom_range(0, 31)), 11'($urandom_range(1, 900))};
			acc(1, CMD_OVER_LIMIT, {16'hFFFF, lim}, 0, 0);
			acc(0, CMD_OVER_LIMIT, 0, {16'h0, lim}, 0);
			chk({16'h0, over_warn_out}, {16'h0, warn(lim, OVER_WARN_PCT)});
			acc(1, CMD_UNDER_LIMIT, {16'h0, lim}, 0, 0);
			acc(0, CMD_UNDER_LIMIT, 0, {16'h0, lim}, 0);
			chk({16'h0, under_warn_out}, {16'h0, warn(lim, UNDER_WARN_PCT)});
		end
		// Memory operations only with the output off
		for (k = 1; k < 5; k++) begin
			acc(1, CMD_CAPTURE_OP, k, 0, 0);
			chk({29'h0, cap_copy_out, cap_store_out, cap_erase_out},
				(k == 4) ? 32'h0 : 32'h1 << (3 - k));
			cyc(1);
			chk({29'h0, cap_copy_out, cap_store_out, cap_erase_out}, 32'h0);
		end
		acc(0, CMD_CAPTURE_OP, 0, 32'h4, 0);
		share_off = 1;
		cyc(2);
		chk({31'h0, rail_off_out}, 32'h1);
		share_off = 0;
		cyc(2);
		chk({31'h0, rail_off_out}, 32'h0);
		// Group behaviour; own rail bit never set by this host
		k = $urandom_range(0, 30);
		acc(1, CMD_LISTEN_VEC, 32'h3 << k, 0, 0);
		spread_en_in = 1;
		on_cmd_in = 1;
		fault_mask = ~(32'h3 << k);
		cyc(4);
		chk({31'h0, output_en_out}, 32'h1);
		fault_mask = 32'h3 << k;
		cyc(3);
		chk({31'h0, output_en_out}, 32'h0);
		fault_mask = 32'h1 << k;
		cyc(4);
		chk({31'h0, output_en_out}, 32'h0);
		fault_mask = 32'h0;
		wait_en(1, 10);
		spread_en_in = 0;
		seq_en_in = 1;
		fault_mask = 32'h2 << k;
		cyc(4);
		chk({31'h0, seq_shutdown_out}, 32'h1);
		fault_mask = 32'h0;
		cyc(4);
		chk({31'h0, seq_shutdown_out}, 32'h0);
		wait_en(1, 10);
		seq_en_in = 0;
		fault_mask = 32'h1 << k;
		cyc(4);
		chk({30'h0, output_en_out, seq_shutdown_out}, 32'h2);
		share_off = 1;
		cyc(2);
		chk({31'h0, rail_off_out}, 32'h0);
		share_off = 0;
		fault_mask = 32'h0;
		// Overvoltage responses against a limit of 100
		acc(1, CMD_LISTEN_VEC, 0, 0, 0);
		acc(1, CMD_OVER_LIMIT, 32'h0064, 0, 0);
		chk({16'h0, over_warn_out}, 32'h005A);
		ov_trip(8'h00);
		ov_trip(8'h40);
		// A clear in the cycle of a standing fault must not win
		clear_faults_in = 1;
		cyc(1);
		clear_faults_in = 0;
		chk({30'h0, alert_n_out, ov_fault_stat_out}, 32'h1);
		ov_trip(8'hC0);
		drv_volt_in = 16'h0060;
		cyc(6);
		chk({31'h0, output_en_out}, 32'h0);
		drv_volt_in = 16'h005E;
		wait_en(1, 6);
		ov_trip(8'h80);
		drv_volt_in = 16'h0000;
		cyc(40);
		chk({31'h0, output_en_out}, 32'h0);
		clear_faults_in = 1;
		wait_en(1, 6);
		clear_faults_in = 0;
		ov_trip(8'h93);
		drv_volt_in = 16'h0000;
		cyc(20);
		chk({31'h0, output_en_out}, 32'h0);
		wait_en(1, 30);
		ov_trip(8'h90);
		cyc(100);
		drv_volt_in = 16'h0000;
		cyc(30);
		chk({31'h0, output_en_out}, 32'h0);
		ov_trip(8'hB8);
		cyc(100);
		drv_volt_in = 16'h0000;
		wait_en(1, 20);
		summarize();
	end
endmodule // test_rail_fault_response_cmds
